// file: hw/csfc_core.sv
// status word, arithmetic and bit-test datapath of the cpu core
`timescale 1ns/100ps
`include "csfc_defines.svh"
module csfc_core
	import csfc_pkg::*;
#(
	parameter int WIDTH = 8
) (
	input wire logic CLK,
	input wire logic RST,
	input wire logic OP_VALID,
	output logic OP_READY,
	input wire logic [3:0] OP_CODE,
	input wire logic [WIDTH-1:0] OP_A,
	input wire logic [WIDTH-1:0] OP_B,
	input wire logic [2:0] BIT_SEL,
	input wire logic [7:0] IRQ_EVENT,
	output logic [7:0] PROCESSOR_STATUS_WORD,
	output logic [7:0] IRQ_PENDING,
	output logic [WIDTH-1:0] RESULT,
	output logic [WIDTH-1:0] RESULT_HI,
	output logic BRANCH_TAKEN,
	output logic DONE
);
	csfc_state_e state;
	csfc_state_e next_state;
	csfc_op_e op;
	logic [7:0] status_word;
	logic [7:0] next_status_word;
	logic [7:0] irq_req;
	logic [7:0] next_irq_req;
	logic [7:0] irq_before;
	logic [7:0] next_irq_before;
	logic last_irq_write;
	logic next_last_irq_write;
	logic [WIDTH-1:0] result;
	logic [WIDTH-1:0] next_result;
	logic [WIDTH-1:0] result_hi;
	logic [WIDTH-1:0] next_result_hi;
	logic branch_taken;
	logic next_branch_taken;
	logic done;
	logic next_done;
	logic [WIDTH:0] div_rem;
	logic [WIDTH:0] next_div_rem;
	logic [WIDTH-1:0] div_quo;
	logic [WIDTH-1:0] next_div_quo;
	logic [WIDTH-1:0] div_den;
	logic [WIDTH-1:0] next_div_den;
	logic [3:0] div_cnt;
	logic [3:0] next_div_cnt;
	logic [7:0] bcd_sum;
	logic bcd_carry;
	logic is_sub;
	logic [WIDTH-1:0] b_eff;
	logic [WIDTH:0] bin_sum;
	logic [7:0] irq_view;
	logic [WIDTH:0] rem_shift;
	logic [2*WIDTH-1:0] product;
	logic accept;

	function automatic logic flag_zero(input logic [WIDTH-1:0] v);
		flag_zero = (v == '0);
	endfunction

	assign op = csfc_op_e'(OP_CODE);
	assign OP_READY = (state == CSFC_ST_IDLE);
	assign accept = OP_VALID && OP_READY;
	assign is_sub = (op == CSFC_SUBTRACT_WITH_BORROW_OP);
	assign b_eff = is_sub ? ~OP_B : OP_B;
	assign bin_sum = {1'b0, OP_A} + {1'b0, b_eff} + {{WIDTH{1'b0}}, status_word[`CSFC_FLAG_C]};
	// product ignores mode and decimal flags
	assign product = OP_A * OP_B;
	// a bit test straight after an irq write reads the pre-write copy
	assign irq_view = last_irq_write ? irq_before : irq_req;
	assign rem_shift = {div_rem[WIDTH-1:0], div_quo[WIDTH-1]};

	csfc_bcd u_bcd (
		.a(OP_A[7:0]),
		.b(OP_B[7:0]),
		.carry_in(status_word[`CSFC_FLAG_C]),
		.sub(is_sub),
		.sum(bcd_sum),
		.carry_out(bcd_carry)
	);

	always_comb begin
		next_state = state;
		next_status_word = status_word;
		next_irq_before = irq_before;
		next_last_irq_write = last_irq_write;
		next_result = result;
		next_result_hi = result_hi;
		next_branch_taken = branch_taken;
		next_done = 1'b0;
		next_div_rem = div_rem;
		next_div_quo = div_quo;
		next_div_den = div_den;
		next_div_cnt = div_cnt;
		// hardware requests win over a program write in the same cycle
		next_irq_req = irq_req | IRQ_EVENT;
		case (state)
			CSFC_ST_IDLE: begin
				if (accept) begin
					next_last_irq_write = (op == CSFC_IRQ_WRITE_OP);
					next_done = (op != CSFC_QUOTIENT_OP);
					case (op)
						CSFC_ADD_OP, CSFC_SUBTRACT_WITH_BORROW_OP: begin
							if (status_word[`CSFC_FLAG_D]) begin
								// decimal result, carry is decimal carry or not-borrow
								next_result = bcd_sum;
								next_status_word[`CSFC_FLAG_C] = bcd_carry;
								// negative, overflow and zero are left as they were
								next_status_word[`CSFC_FLAG_N] = status_word[`CSFC_FLAG_N];
							end else begin
								next_result = bin_sum[WIDTH-1:0];
								next_status_word[`CSFC_FLAG_C] = bin_sum[WIDTH];
								next_status_word[`CSFC_FLAG_Z] = flag_zero(bin_sum[WIDTH-1:0]);
								next_status_word[`CSFC_FLAG_N] = bin_sum[WIDTH-1];
								next_status_word[`CSFC_FLAG_V] = (OP_A[WIDTH-1] ^ bin_sum[WIDTH-1])
									& (b_eff[WIDTH-1] ^ bin_sum[WIDTH-1]);
							end
						end
						CSFC_PRODUCT_OP: begin
							// status word untouched
							next_result = product[WIDTH-1:0];
							next_result_hi = product[2*WIDTH-1:WIDTH];
						end
						CSFC_QUOTIENT_OP: begin
							if (flag_zero(OP_B)) begin
								next_result = `CSFC_DIV_ZERO_QUO;
								next_result_hi = OP_A;
								next_done = 1'b1;
							end else begin
								// divider runs the same in every flag setting
								next_state = CSFC_ST_DIV;
								next_div_rem = '0;
								next_div_quo = OP_A;
								next_div_den = OP_B;
								next_div_cnt = `CSFC_DIV_STEPS;
							end
						end
						CSFC_PULL_STATUS_OP: begin
							// new flags are valid from the next op on
							next_status_word = OP_A[7:0];
						end
						CSFC_CARRY_SET_OP: begin
							next_status_word[`CSFC_FLAG_C] = 1'b1;
						end
						CSFC_CARRY_CLEAR_OP: begin
							next_status_word[`CSFC_FLAG_C] = 1'b0;
						end
						CSFC_DECIMAL_ON_OP: begin
							next_status_word[`CSFC_FLAG_D] = 1'b1;
						end
						CSFC_DECIMAL_OFF_OP: begin
							next_status_word[`CSFC_FLAG_D] = 1'b0;
						end
						CSFC_MODE_ON_OP: begin
							next_status_word[`CSFC_FLAG_T] = 1'b1;
						end
						CSFC_MODE_OFF_OP: begin
							next_status_word[`CSFC_FLAG_T] = 1'b0;
						end
						CSFC_IRQ_WRITE_OP: begin
							next_irq_before = irq_req;
							next_irq_req = OP_A[7:0] | IRQ_EVENT;
						end
						CSFC_BRANCH_BIT_CLEAR_OP: begin
							next_branch_taken = ~irq_view[BIT_SEL];
						end
						CSFC_BRANCH_BIT_SET_OP: begin
							next_branch_taken = irq_view[BIT_SEL];
						end
						default: begin
							next_done = 1'b1;
						end
					endcase
				end
			end
			CSFC_ST_DIV: begin
				// one restoring step per cycle, status word untouched
				if (rem_shift >= {1'b0, div_den}) begin
					next_div_rem = rem_shift - {1'b0, div_den};
					next_div_quo = {div_quo[WIDTH-2:0], 1'b1};
				end else begin
					next_div_rem = rem_shift;
					next_div_quo = {div_quo[WIDTH-2:0], 1'b0};
				end
				next_div_cnt = 4'(div_cnt - 4'h1);
				if (div_cnt == 4'h1) begin
					next_state = CSFC_ST_IDLE;
					next_result = next_div_quo;
					next_result_hi = next_div_rem[WIDTH-1:0];
					next_done = 1'b1;
				end
			end
			default: begin
				next_state = CSFC_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			state <= CSFC_ST_IDLE;
			// only the interrupt inhibit flag is defined, others held at zero
			status_word <= `CSFC_STATUS_RESET;
			irq_req <= `CSFC_IRQ_RESET;
			irq_before <= `CSFC_IRQ_RESET;
			last_irq_write <= 1'b0;
			result <= '0;
			result_hi <= '0;
			branch_taken <= 1'b0;
			done <= 1'b0;
			div_rem <= '0;
			div_quo <= '0;
			div_den <= '0;
			div_cnt <= 4'h0;
		end else begin
			state <= next_state;
			status_word <= next_status_word;
			irq_req <= next_irq_req;
			irq_before <= next_irq_before;
			last_irq_write <= next_last_irq_write;
			result <= next_result;
			result_hi <= next_result_hi;
			branch_taken <= next_branch_taken;
			done <= next_done;
			div_rem <= next_div_rem;
			div_quo <= next_div_quo;
			div_den <= next_div_den;
			div_cnt <= next_div_cnt;
		end
	end

	assign PROCESSOR_STATUS_WORD = status_word;
	assign IRQ_PENDING = irq_req;
	assign RESULT = result;
	assign RESULT_HI = result_hi;
	assign BRANCH_TAKEN = branch_taken;
	assign DONE = done;
endmodule

// file: hw/csfc_defines.svh
// field positions, reset values, counts and constants of the status-flag core
`ifndef CSFC_DEFINES_SVH
`define CSFC_DEFINES_SVH
`define CSFC_FLAG_C 0
`define CSFC_FLAG_Z 1
`define CSFC_FLAG_I 2
`define CSFC_FLAG_D 3
`define CSFC_FLAG_B 4
`define CSFC_FLAG_T 5
`define CSFC_FLAG_V 6
`define CSFC_FLAG_N 7
`define CSFC_STATUS_RESET 8'h04
`define CSFC_IRQ_RESET 8'h00
`define CSFC_DIV_STEPS 4'h8
`define CSFC_DIV_ZERO_QUO 8'hff
`define CSFC_BCD_MAX 5'h09
`define CSFC_BCD_ADJ 5'h06
`endif

// file: hw/csfc_pkg.sv
// types of the status-flag core
package csfc_pkg;
	typedef enum logic [3:0] {
		CSFC_IDLE_OP = 4'h0,
		CSFC_ADD_OP = 4'h1,
		CSFC_SUBTRACT_WITH_BORROW_OP = 4'h2,
		CSFC_PRODUCT_OP = 4'h3,
		CSFC_QUOTIENT_OP = 4'h4,
		CSFC_PULL_STATUS_OP = 4'h5,
		CSFC_CARRY_SET_OP = 4'h6,
		CSFC_CARRY_CLEAR_OP = 4'h7,
		CSFC_DECIMAL_ON_OP = 4'h8,
		CSFC_DECIMAL_OFF_OP = 4'h9,
		CSFC_MODE_ON_OP = 4'ha,
		CSFC_MODE_OFF_OP = 4'hb,
		CSFC_IRQ_WRITE_OP = 4'hc,
		CSFC_BRANCH_BIT_CLEAR_OP = 4'hd,
		CSFC_BRANCH_BIT_SET_OP = 4'he
	} csfc_op_e;
	typedef enum logic [1:0] {
		CSFC_ST_IDLE = 2'b01,
		CSFC_ST_DIV = 2'b10
	} csfc_state_e;
endpackage

// file: hw/csfc_bcd.sv
// packed two-digit decimal adder and subtractor
`timescale 1ns/100ps
`include "csfc_defines.svh"
module csfc_bcd (
	input wire logic [7:0] a,
	input wire logic [7:0] b,
	input wire logic carry_in,
	input wire logic sub,
	output logic [7:0] sum,
	output logic carry_out
);
	logic [2:0] chain;
	assign chain[0] = carry_in;
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : digit
			logic [4:0] raw;
			logic [3:0] dig;
			logic over;
			always_comb begin
				if (sub) begin
					raw = {1'b0, a[4*g+3:4*g]} - {1'b0, b[4*g+3:4*g]} - {4'h0, ~chain[g]};
					over = raw[4];
					dig = over ? 4'(raw - `CSFC_BCD_ADJ) : raw[3:0];
				end else begin
					raw = {1'b0, a[4*g+3:4*g]} + {1'b0, b[4*g+3:4*g]} + {4'h0, chain[g]};
					over = raw > `CSFC_BCD_MAX;
					dig = over ? 4'(raw + `CSFC_BCD_ADJ) : raw[3:0];
				end
			end
			assign sum[4*g+3:4*g] = dig;
			// carry out of a digit is a decimal carry, or the inverse of a borrow
			assign chain[g+1] = sub ? ~over : over;
		end
	endgenerate
	assign carry_out = chain[2];
endmodule

// file: tb/csfc_core_assertions.sv
// assertion checker for the status-flag core
`timescale 1ns/100ps
module csfc_core_assertions (
	input wire logic CLK,
	input wire logic RST,
	input wire logic OP_VALID,
	input wire logic OP_READY,
	input wire logic [3:0] OP_CODE,
	input wire logic [7:0] OP_A,
	input wire logic [7:0] OP_B,
	input wire logic [2:0] BIT_SEL,
	input wire logic [7:0] PROCESSOR_STATUS_WORD,
	input wire logic [7:0] IRQ_PENDING,
	input wire logic [7:0] RESULT,
	input wire logic [7:0] RESULT_HI,
	input wire logic BRANCH_TAKEN,
	input wire logic DONE
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	wire take = OP_VALID && OP_READY;
	wire [7:0] status = PROCESSOR_STATUS_WORD;
	chk_reset_status: assert property (disable iff (1'b0) RST |-> status == 8'h04)
		else $error("status word not at reset value");
	chk_product_ps: assert property (take && OP_CODE == 4'h3 |=> $stable(status))
		else $error("product changed status word");
	chk_divide_ps: assert property (take && OP_CODE == 4'h4 && OP_B != 0 |=> $stable(status) [*8])
		else $error("divide changed status word");
	chk_product_value: assert property (take && OP_CODE == 4'h3 |=> {RESULT_HI, RESULT} == $past(OP_A) * $past(OP_B))
		else $error("wrong product");
	chk_divide_value: assert property (take && OP_CODE == 4'h4 && OP_B != 0 |-> ##9 DONE
		&& RESULT == $past(OP_A, 9) / $past(OP_B, 9) && RESULT_HI == $past(OP_A, 9) % $past(OP_B, 9))
		else $error("wrong quotient or late");
	chk_divide_busy: assert property (take && OP_CODE == 4'h4 && OP_B != 0 |=> (!OP_READY) [*8] ##1 OP_READY)
		else $error("divider busy time wrong");
	chk_decimal_nvz: assert property (take && status[3] && OP_CODE inside {4'h1, 4'h2} |=> $stable({status[7:6], status[1]}))
		else $error("decimal op touched n v z");
	chk_branch_old: assert property (take && OP_CODE == 4'hc ##1 take && OP_CODE == 4'he
		|=> BRANCH_TAKEN == $past(IRQ_PENDING[BIT_SEL], 2))
		else $error("branch saw new request bits");
	cover property (take && OP_CODE == 4'h4 && OP_B != 0);
	cover property (take && status[3] && OP_CODE == 4'h2);
	cover property (take && OP_CODE == 4'hc ##1 take && OP_CODE == 4'he);
endmodule
bind csfc_core csfc_core_assertions u_chk (.CLK(CLK), .RST(RST), .OP_VALID(OP_VALID), .OP_READY(OP_READY),
	.OP_CODE(OP_CODE), .OP_A(OP_A), .OP_B(OP_B), .BIT_SEL(BIT_SEL),
	.PROCESSOR_STATUS_WORD(PROCESSOR_STATUS_WORD), .IRQ_PENDING(IRQ_PENDING),
	.RESULT(RESULT), .RESULT_HI(RESULT_HI), .BRANCH_TAKEN(BRANCH_TAKEN), .DONE(DONE));

// file: tb/csfc_core_tb_top.sv
// self-checking bench for the status-flag core
`timescale 1ns/100ps
module csfc_core_tb_top;
	logic clk, rst, op_valid, op_ready, branch_taken, done;
	logic [3:0] op_code;
	logic [7:0] op_a, op_b, status_word, irq_pending, result, result_hi, irq_event;
	logic [2:0] bit_sel;
	int num_errors = 0;
	int n_checks = 0;
	csfc_core u_dut (.CLK(clk), .RST(rst), .OP_VALID(op_valid), .OP_READY(op_ready), .OP_CODE(op_code),
		.OP_A(op_a), .OP_B(op_b), .BIT_SEL(bit_sel), .IRQ_EVENT(irq_event), .PROCESSOR_STATUS_WORD(status_word),
		.IRQ_PENDING(irq_pending),
		.RESULT(result), .RESULT_HI(result_hi), .BRANCH_TAKEN(branch_taken), .DONE(done));
	initial begin
		clk = 0;
		forever #4 clk = ~clk;
	end
	task automatic give_verdict();
		if (num_errors == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	// w: release the request and wait for completion
	task automatic op(input logic [3:0] c, input logic [7:0] a, input logic [7:0] b, input bit w);
		int k = 0;
		op_valid = 1;
		op_code = c;
		op_a = a;
		op_b = b;
		@(posedge clk);
		#1;
		if (w) begin
			op_valid = 0;
			while (done !== 1'b1 && k < 20) begin
				@(posedge clk);
				#1;
				k++;
			end
			if (done !== 1'b1) begin
				num_errors++;
				give_verdict();
			end
			// one idle edge before the next request is raised
			@(posedge clk);
			#1;
		end
	endtask
	function automatic logic [8:0] bcd(input logic [7:0] a, input logic [7:0] b, input logic c, input bit sub);
		int va, vb, s;
		va = a[7:4] * 10 + a[3:0];
		vb = b[7:4] * 10 + b[3:0];
		s = sub ? va - vb - 1 + c : va + vb + c;
		bcd[8] = sub ? s >= 0 : s > 99;
		s = (s + 100) % 100;
		bcd[7:0] = {4'(s / 10), 4'(s % 10)};
	endfunction
	function automatic logic [7:0] rb();
		rb = {4'($urandom % 10), 4'($urandom % 10)};
	endfunction
	task automatic dec_case(input bit sub, input logic [7:0] a, input logic [7:0] b, input logic c);
		logic [7:0] p;
		logic [8:0] e;
		op(c ? 4'h6 : 4'h7, 8'h00, 8'h00, 1);
		p = status_word;
		e = bcd(a, b, c, sub);
		op(sub ? 4'h2 : 4'h1, a, b, 1);
		chk("decimal", {7'h0, e}, {7'h0, status_word[0], result});
		chk("nvz", {13'h0, p[7:6], p[1]}, {13'h0, status_word[7:6], status_word[1]});
		op(4'h0, 8'h00, 8'h00, 1);
	endtask
	initial begin
		logic [7:0] a, b, p;
		rst = 1;
		op_valid = 0;
		op_code = 0;
		op_a = 0;
		op_b = 0;
		bit_sel = 0;
		irq_event = 0;
		void'($urandom(18));
		repeat (8) @(posedge clk);
		#1;
		rst = 0;
		chk("reset status", 16'h0004, {8'h0, status_word});
		op(4'h8, 8'h00, 8'h00, 1);
		op(4'hb, 8'h00, 8'h00, 1);
		dec_case(0, 8'h99, 8'h99, 1);
		dec_case(1, 8'h00, 8'h00, 0);
		repeat (30) dec_case(1'($urandom), rb(), rb(), 1'($urandom));
		for (int i = 0; i < 30; i++) begin
			op({3'h4, 1'($urandom)}, 8'h00, 8'h00, 1);
			op({3'h5, 1'($urandom)}, 8'h00, 8'h00, 1);
			a = 8'($urandom);
			b = (i == 0) ? 8'h00 : 8'($urandom);
			p = status_word;
			op(4'h3, a, b, 1);
			chk("product", 16'(a) * 16'(b), {result_hi, result});
			op(4'h4, a, b, 1);
			chk("quotient", (b != 8'h00) ? {a % b, a / b} : {a, 8'hff}, {result_hi, result});
			chk("ready", 16'h1, {15'h0, op_ready});
			chk("status kept", {8'h0, p}, {8'h0, status_word});
		end
		a = 8'($urandom) & 8'hfb;
		op(4'h5, a, 8'h00, 1);
		op(4'h0, 8'h00, 8'h00, 1);
		chk("pulled status", {8'h0, a}, {8'h0, status_word});
		rst = 1;
		repeat (2) @(posedge clk);
		#1;
		rst = 0;
		chk("reset again", 16'h0004, {8'h0, status_word});
		op(4'h9, 8'h00, 8'h00, 1);
		op(4'hb, 8'h00, 8'h00, 1);
		bit_sel = 3'h3;
		op(4'hc, 8'hff, 8'h00, 0);
		chk("pending", 16'h00ff, {8'h0, irq_pending});
		op(4'he, 8'h00, 8'h00, 1);
		chk("branch old", 16'h0, {15'h0, branch_taken});
		op(4'h0, 8'h00, 8'h00, 1);
		op(4'he, 8'h00, 8'h00, 1);
		chk("branch live", 16'h1, {15'h0, branch_taken});
		op(4'hc, 8'h00, 8'h00, 0);
		op(4'hd, 8'h00, 8'h00, 1);
		chk("clear old", 16'h0, {15'h0, branch_taken});
		irq_event = 8'h10;
		op(4'hc, 8'h01, 8'h00, 1);
		irq_event = 8'h00;
		chk("pending event", 16'h0011, {8'h0, irq_pending});
		give_verdict();
	end
endmodule
